/* lsr_pkg.sv */
`default_nettype none

package lsr_pkg;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [4:0] LSR_OFF_CTRL = 5'h00;
  localparam logic [4:0] LSR_OFF_INTC = 5'h02;
  localparam logic [4:0] LSR_OFF_TLL = 5'h03;
  localparam logic [4:0] LSR_OFF_TLH = 5'h04;
  localparam logic [4:0] LSR_OFF_THL = 5'h05;
  localparam logic [4:0] LSR_OFF_THH = 5'h06;
  localparam logic [4:0] LSR_OFF_ID = 5'h12;
  localparam logic [4:0] LSR_OFF_CH0L = 5'h14;
  localparam logic [4:0] LSR_OFF_CH0H = 5'h15;
  localparam logic [4:0] LSR_OFF_CH1L = 5'h16;
  localparam logic [4:0] LSR_OFF_CH1H = 5'h17;
  localparam logic [4:0] LSR_OFF_TIML = 5'h18;
  localparam logic [4:0] LSR_OFF_TIMH = 5'h19;
  localparam logic [4:0] LSR_OFF_VAR = 5'h1E;

  // ------------------------------------------------------------
  // Command byte layout
  // ------------------------------------------------------------
  localparam int LSR_CMD_BIT = 7;
  localparam int LSR_TYPE_HI = 6;
  localparam int LSR_TYPE_LO = 5;
  localparam logic [1:0] LSR_TYPE_BYTE = 2'h0;
  localparam logic [1:0] LSR_TYPE_WORD = 2'h1;
  localparam logic [1:0] LSR_TYPE_SPECIAL = 2'h3;
  localparam logic [4:0] LSR_SPECIAL_IRQ_CLR = 5'h01;

  // ------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------
  localparam int LSR_CTRL_POWER = 0;
  localparam int LSR_CTRL_ADC_EN = 1;
  localparam int LSR_INTC_HALT = 6;
  localparam int LSR_INTC_MODE = 4;
  localparam int LSR_INTC_PERS_HI = 3;
  localparam int LSR_INTC_PERS_LO = 0;
  localparam logic [7:0] LSR_BYTE_RST = 8'h00;
  localparam logic [15:0] LSR_WORD_RST = 16'h0000;
  localparam logic [3:0] LSR_PERS_EVERY = 4'h0;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam real LSR_TICK_US = 10.9;
  localparam real LSR_CLK_MHZ = 100.0;
  localparam int LSR_TICK_CYC = $rtoi(LSR_TICK_US * LSR_CLK_MHZ + 0.5);
  localparam int LSR_TICK_W = 11;

endpackage

`default_nettype wire

/* lsr_word_xfer.sv */
`timescale 1ns/10ps
`default_nettype none

// Toggle handshake carrying a word from the source clock to the destination clock
module lsr_word_xfer #(
  parameter int W = 48
) (
  input wire logic src_clk,
  input wire logic src_resetn,
  input wire logic [W-1:0] src_data,
  input wire logic dst_clk,
  input wire logic dst_resetn,
  output logic [W-1:0] dst_data
);
  typedef struct packed {
    logic [W-1:0] hold;
    logic req;
    logic ack_s1;
    logic ack_s2;
  } lsr_xs_s;
  typedef struct packed {
    logic [W-1:0] data;
    logic req_s1;
    logic req_s2;
    logic ack;
  } lsr_xd_s;

  lsr_xs_s s_r, s_nxt;
  lsr_xd_s d_r, d_nxt;

  // Source launches a new snapshot only once the last one was acknowledged
  always_comb begin
    s_nxt = s_r;
    s_nxt.ack_s1 = d_r.ack;
    s_nxt.ack_s2 = s_r.ack_s1;
    if (s_r.ack_s2 == s_r.req) begin
      s_nxt.hold = src_data;
      s_nxt.req = ~s_r.req;
    end
  end

  always_ff @(posedge src_clk) begin
    if (!src_resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Hold is stable while req differs from ack, so the bus is safe to sample
  always_comb begin
    d_nxt = d_r;
    d_nxt.req_s1 = s_r.req;
    d_nxt.req_s2 = d_r.req_s1;
    if (d_r.req_s2 != d_r.ack) begin
      d_nxt.data = s_r.hold;
      d_nxt.ack = d_r.req_s2;
    end
  end

  always_ff @(posedge dst_clk) begin
    if (!dst_resetn) begin
      d_r <= '0;
    end else begin
      d_r <= d_nxt;
    end
  end

  assign dst_data = d_r.data;

endmodule

`default_nettype wire

/* lsr_readout.sv */
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Identification register is constant, part and revision.
// - Results split low/high at 14h and 16h.
// - Result registers read-only, zero after power-up.
// - Low-byte read copies upper byte to shadow.
// - Upper read returns shadow despite newer conversions.
// - Word read returns low then next upper.
// - Manual integration counts 10.9 us ticks.
// - Sixteen-bit tick count covers 714.3 ms.
// - Variant register at 1Eh, writable, bits 5:4; the code stores and returns all eight bits.
// - Powered down until control written with 01h.
// - Control value 03h powers and enables both.
// - Word command at 14h reads 14h then 15h.
// - Interrupt control zero disables interrupts.
// - Only channel 0 compared against two thresholds.
// - Persistence 1 interrupts at first outside result.
// - Persistence N needs N consecutive outside results.
// - Interrupt low until special clear command.
// - Persistence zero interrupts every conversion.
// - Outside means at/below low or above high.
// - Halt-on-interrupt bit stops integration while asserted.
// - Mode bit 4 selects disabled or level.
// - Thresholds built from byte registers 3h-6h.
module lsr_readout
  import lsr_pkg::*;
#(
  parameter logic [3:0] PART_NUMBER = 4'hA,      // Arbitrary value
  parameter logic [3:0] SILICON_REVISION = 4'h5, // Arbitrary value
  parameter int TICK_CYC = LSR_TICK_CYC
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic link_clk,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic wr_valid,
  input wire logic [7:0] wr_byte,
  input wire logic rd_valid,
  output logic [7:0] rd_byte,
  input wire logic conv_done,
  input wire logic [15:0] ch0_in,
  input wire logic [15:0] ch1_in,
  input wire logic manual_start,
  input wire logic manual_active,
  output logic power_on,
  output logic adc_enable,
  output logic integration_halt,
  output logic irq_n
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic [4:0] ptr;
    logic word;
    logic [7:0] ctrl;
    logic [7:0] intc;
    logic [15:0] tl;
    logic [15:0] th;
    logic [7:0] variant;
    logic [7:0] sh0;
    logic [7:0] sh1;
    logic [7:0] rdata;
    logic cfg_tgl;
    logic clr_tgl;
  } lsr_lk_s;

  typedef struct packed {
    logic cfg_s1;
    logic cfg_s2;
    logic cfg_s3;
    logic clr_s1;
    logic clr_s2;
    logic clr_s3;
    logic [7:0] ctrl;
    logic [7:0] intc;
    logic [15:0] tl;
    logic [15:0] th;
    logic [15:0] ch0;
    logic [15:0] ch1;
    logic [LSR_TICK_W-1:0] div;
    logic [15:0] ticks;
    logic [3:0] cnt;
    logic flag;
    logic halt;
    logic irq_n;
  } lsr_rf_s;

  lsr_lk_s lk_r, lk_nxt;
  lsr_rf_s rf_r, rf_nxt;
  logic [47:0] lk_res;
  logic lk_resetn;
  logic clr_evt;
  logic conv_ok;
  logic [3:0] persist;
  logic [4:0] cnt_inc;

  localparam logic [LSR_TICK_W-1:0] TICK_LAST = LSR_TICK_W'(TICK_CYC - 1);

  function automatic logic outside(input logic [15:0] v, input logic [15:0] lo,
                                   input logic [15:0] hi);
    outside = (v <= lo) || (v > hi);
  endfunction

  function automatic logic [4:0] next_ptr(input logic [4:0] p, input logic w);
    next_ptr = w ? 5'(p + 5'h01) : p;
  endfunction

  // ------------------------------------------------------------
  // Result crossing into the link domain
  // ------------------------------------------------------------
  lsr_word_xfer #(.W(48)) u_res_xfer (
    .src_clk(ref_clk),
    .src_resetn(resetn),
    .src_data({rf_r.ticks, rf_r.ch1, rf_r.ch0}),
    .dst_clk(link_clk),
    .dst_resetn(lk_resetn),
    .dst_data(lk_res)
  );

  // ------------------------------------------------------------
  // Link domain: command pointer and register file
  // ------------------------------------------------------------
  assign lk_resetn = lk_r.rst_s2;

  always_comb begin
    lk_nxt = lk_r;
    lk_nxt.rst_s1 = resetn;
    lk_nxt.rst_s2 = lk_r.rst_s1;
    if (cmd_valid && cmd_byte[LSR_CMD_BIT]) begin
      if (cmd_byte[LSR_TYPE_HI:LSR_TYPE_LO] == LSR_TYPE_SPECIAL) begin
        if (cmd_byte[4:0] == LSR_SPECIAL_IRQ_CLR) begin
          lk_nxt.clr_tgl = ~lk_r.clr_tgl;
        end
      end else begin
        lk_nxt.ptr = cmd_byte[4:0];
        lk_nxt.word = cmd_byte[LSR_TYPE_HI:LSR_TYPE_LO] == LSR_TYPE_WORD;
      end
    end else if (wr_valid) begin
      case (lk_r.ptr)
        LSR_OFF_CTRL: lk_nxt.ctrl = wr_byte;
        LSR_OFF_INTC: lk_nxt.intc = wr_byte;
        LSR_OFF_TLL: lk_nxt.tl[7:0] = wr_byte;
        LSR_OFF_TLH: lk_nxt.tl[15:8] = wr_byte;
        LSR_OFF_THL: lk_nxt.th[7:0] = wr_byte;
        LSR_OFF_THH: lk_nxt.th[15:8] = wr_byte;
        LSR_OFF_VAR: lk_nxt.variant = wr_byte;
        default: lk_nxt.ctrl = lk_r.ctrl;
      endcase
      lk_nxt.cfg_tgl = ~lk_r.cfg_tgl;
      lk_nxt.ptr = next_ptr(lk_r.ptr, lk_r.word);
    end else if (rd_valid) begin
      case (lk_r.ptr)
        LSR_OFF_CTRL: lk_nxt.rdata = lk_r.ctrl;
        LSR_OFF_INTC: lk_nxt.rdata = lk_r.intc;
        LSR_OFF_TLL: lk_nxt.rdata = lk_r.tl[7:0];
        LSR_OFF_TLH: lk_nxt.rdata = lk_r.tl[15:8];
        LSR_OFF_THL: lk_nxt.rdata = lk_r.th[7:0];
        LSR_OFF_THH: lk_nxt.rdata = lk_r.th[15:8];
        LSR_OFF_ID: lk_nxt.rdata = {PART_NUMBER, SILICON_REVISION};
        LSR_OFF_CH0L: begin
          lk_nxt.rdata = lk_res[7:0];
          lk_nxt.sh0 = lk_res[15:8];
        end
        LSR_OFF_CH0H: lk_nxt.rdata = lk_r.sh0;
        LSR_OFF_CH1L: begin
          lk_nxt.rdata = lk_res[23:16];
          lk_nxt.sh1 = lk_res[31:24];
        end
        LSR_OFF_CH1H: lk_nxt.rdata = lk_r.sh1;
        LSR_OFF_TIML: lk_nxt.rdata = lk_res[39:32];
        LSR_OFF_TIMH: lk_nxt.rdata = lk_res[47:40];
        LSR_OFF_VAR: lk_nxt.rdata = lk_r.variant;
        default: lk_nxt.rdata = LSR_BYTE_RST;
      endcase
      lk_nxt.ptr = next_ptr(lk_r.ptr, lk_r.word);
    end
  end

  always_ff @(posedge link_clk) begin
    if (!lk_resetn) begin
      lk_r <= '0;
      lk_r.rst_s1 <= lk_nxt.rst_s1;
      lk_r.rst_s2 <= lk_nxt.rst_s2;
    end else begin
      lk_r <= lk_nxt;
    end
  end

  // ------------------------------------------------------------
  // Reference domain: capture, tick timer, interrupt
  // ------------------------------------------------------------
  assign clr_evt = rf_r.clr_s2 != rf_r.clr_s3;
  assign conv_ok = conv_done && rf_r.ctrl[LSR_CTRL_POWER] && rf_r.ctrl[LSR_CTRL_ADC_EN]
                   && !rf_r.halt;
  assign persist = rf_r.intc[LSR_INTC_PERS_HI:LSR_INTC_PERS_LO];
  // A clear in the same cycle restarts the count from this conversion
  assign cnt_inc = {1'b0, (clr_evt ? 4'h0 : rf_r.cnt)} + 5'h01;

  always_comb begin
    rf_nxt = rf_r;
    rf_nxt.cfg_s1 = lk_r.cfg_tgl;
    rf_nxt.cfg_s2 = rf_r.cfg_s1;
    rf_nxt.cfg_s3 = rf_r.cfg_s2;
    rf_nxt.clr_s1 = lk_r.clr_tgl;
    rf_nxt.clr_s2 = rf_r.clr_s1;
    rf_nxt.clr_s3 = rf_r.clr_s2;
    // Config bytes sit still since the write, so sampling after the toggle is safe
    if (rf_r.cfg_s2 != rf_r.cfg_s3) begin
      rf_nxt.ctrl = lk_r.ctrl;
      rf_nxt.intc = lk_r.intc;
      rf_nxt.tl = lk_r.tl;
      rf_nxt.th = lk_r.th;
    end
    if (manual_start) begin
      rf_nxt.div = '0;
      rf_nxt.ticks = LSR_WORD_RST;
    end else if (manual_active) begin
      if (rf_r.div == TICK_LAST) begin
        rf_nxt.div = '0;
        rf_nxt.ticks = 16'(rf_r.ticks + 16'h0001);
      end else begin
        rf_nxt.div = LSR_TICK_W'(rf_r.div + 1'b1);
      end
    end
    // Clear first so that a set in the same cycle wins
    if (clr_evt) begin
      rf_nxt.flag = 1'b0;
      rf_nxt.cnt = 4'h0;
    end
    if (conv_ok) begin
      rf_nxt.ch0 = ch0_in;
      rf_nxt.ch1 = ch1_in;
      if (rf_r.intc[LSR_INTC_MODE]) begin
        if (persist == LSR_PERS_EVERY) begin
          rf_nxt.flag = 1'b1;
        end else if (outside(ch0_in, rf_r.tl, rf_r.th)) begin
          if (cnt_inc >= {1'b0, persist}) begin
            rf_nxt.flag = 1'b1;
            rf_nxt.cnt = persist;
          end else begin
            rf_nxt.cnt = cnt_inc[3:0];
          end
        end else begin
          rf_nxt.cnt = 4'h0;
        end
      end
    end
    if (!rf_r.intc[LSR_INTC_MODE]) begin
      rf_nxt.flag = 1'b0;
      rf_nxt.cnt = 4'h0;
    end
    rf_nxt.halt = rf_nxt.flag && rf_r.intc[LSR_INTC_HALT];
    rf_nxt.irq_n = ~rf_nxt.flag;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rf_r <= '0;
      rf_r.irq_n <= 1'b1;
    end else begin
      rf_r <= rf_nxt;
    end
  end

  assign rd_byte = lk_r.rdata;
  assign power_on = rf_r.ctrl[LSR_CTRL_POWER];
  assign adc_enable = rf_r.ctrl[LSR_CTRL_ADC_EN];
  assign integration_halt = rf_r.halt;
  assign irq_n = rf_r.irq_n;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_id_constant: assert property (@(posedge link_clk) disable iff (!lk_resetn)
    rd_valid && !cmd_valid && !wr_valid && lk_r.ptr == LSR_OFF_ID
    |=> rd_byte == {PART_NUMBER, SILICON_REVISION})
    else $error("id register changed");

  a_result_reset: assert property (@(posedge ref_clk)
    !resetn |=> rf_r.ch0 == LSR_WORD_RST && rf_r.ch1 == LSR_WORD_RST)
    else $error("results not cleared by reset");

  a_shadow_catch: assert property (@(posedge link_clk) disable iff (!lk_resetn)
    rd_valid && !cmd_valid && !wr_valid && lk_r.ptr == LSR_OFF_CH0L
    |=> lk_r.sh0 == $past(lk_res[15:8]) && rd_byte == $past(lk_res[7:0]))
    else $error("shadow not loaded on low read");

  a_shadow_return: assert property (@(posedge link_clk) disable iff (!lk_resetn)
    rd_valid && !cmd_valid && !wr_valid && lk_r.ptr == LSR_OFF_CH0H
    |=> rd_byte == $past(lk_r.sh0))
    else $error("upper read not from shadow");

  a_word_step: assert property (@(posedge link_clk) disable iff (!lk_resetn)
    rd_valid && !cmd_valid && !wr_valid && lk_r.word && lk_r.ptr == LSR_OFF_CH0L
    |=> lk_r.ptr == LSR_OFF_CH0H && lk_r.word)
    else $error("word read did not step address");

  a_tick_step: assert property (@(posedge ref_clk) disable iff (!resetn)
    !manual_start && manual_active && rf_r.div == TICK_LAST
    |=> rf_r.ticks == 16'($past(rf_r.ticks) + 16'h0001) && rf_r.div == '0)
    else $error("tick count not advanced");

  a_every_conv: assert property (@(posedge ref_clk) disable iff (!resetn)
    conv_ok && rf_r.intc[LSR_INTC_MODE] && persist == LSR_PERS_EVERY |=> !irq_n)
    else $error("no interrupt at end of conversion");

  a_first_outside: assert property (@(posedge ref_clk) disable iff (!resetn)
    conv_ok && rf_r.intc[LSR_INTC_MODE] && persist == 4'h1
    && outside(ch0_in, rf_r.tl, rf_r.th) |=> !irq_n)
    else $error("persistence one missed interrupt");

  a_inside_reset: assert property (@(posedge ref_clk) disable iff (!resetn)
    conv_ok && persist != LSR_PERS_EVERY && !outside(ch0_in, rf_r.tl, rf_r.th)
    |=> rf_r.cnt == 4'h0)
    else $error("outside count not reset");

  a_irq_latched: assert property (@(posedge ref_clk) disable iff (!resetn)
    !irq_n && !clr_evt && rf_r.intc[LSR_INTC_MODE] |=> !irq_n)
    else $error("interrupt released without clear");

  a_irq_disabled: assert property (@(posedge ref_clk) disable iff (!resetn)
    !rf_r.intc[LSR_INTC_MODE] |=> irq_n)
    else $error("interrupt while disabled");

  a_halt_freeze: assert property (@(posedge ref_clk) disable iff (!resetn)
    integration_halt |=> $stable(rf_r.ch0) && $stable(rf_r.ch1))
    else $error("results moved while halted");

  c_word_read: cover property (@(posedge link_clk) disable iff (!lk_resetn)
    rd_valid && lk_r.word && lk_r.ptr == LSR_OFF_CH0H);
  c_persist_hit: cover property (@(posedge ref_clk) disable iff (!resetn)
    $fell(irq_n) && persist > 4'h2);
  c_irq_clear: cover property (@(posedge ref_clk) disable iff (!resetn)
    !irq_n && clr_evt ##1 irq_n);
  c_halted: cover property (@(posedge ref_clk) disable iff (!resetn)
    $rose(integration_halt));

endmodule

`default_nettype wire

/* lsr_host_model.sv */
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------
// Host side of the link register port
// ------------------------------------------------------------
module lsr_host_model (
  input wire logic link_clk,
  output logic cmd_valid,
  output logic [7:0] cmd_byte,
  output logic wr_valid,
  output logic [7:0] wr_byte,
  output logic rd_valid,
  input wire logic [7:0] rd_byte
);
  initial begin
    idle();
  end

  task automatic idle();
    cmd_valid = 1'b0;
    cmd_byte = 8'h00;
    wr_valid = 1'b0;
    wr_byte = 8'h00;
    rd_valid = 1'b0;
  endtask

  // Released data lines show the inverse, so a stale byte cannot pass
  task automatic cmd(input logic [7:0] b);
    @(posedge link_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_byte = b;
    @(posedge link_clk);
    #1;
    cmd_valid = 1'b0;
    cmd_byte = ~b;
  endtask

  task automatic wr(input logic [7:0] b);
    @(posedge link_clk);
    #1;
    wr_valid = 1'b1;
    wr_byte = b;
    @(posedge link_clk);
    #1;
    wr_valid = 1'b0;
    wr_byte = ~b;
  endtask

  // Answer lands one link cycle after the strobe and then holds
  task automatic rd(output logic [7:0] b);
    @(posedge link_clk);
    #1;
    rd_valid = 1'b1;
    @(posedge link_clk);
    #1;
    rd_valid = 1'b0;
    @(posedge link_clk);
    #1;
    b = rd_byte;
  endtask

  task automatic rd_word(input logic [7:0] c, output logic [7:0] lo, output logic [7:0] hi);
    cmd(c);
    rd(lo);
    rd(hi);
  endtask
endmodule

`default_nettype wire

/* tb_top.sv */
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, e) \
  begin \
    n_tests++; \
    if ((a) !== (e)) begin \
      n_fail++; \
      $display("wrong value at %0t: got %h exp %h", $time, a, e); \
    end \
  end

module tb_top;
  import lsr_pkg::*;
  localparam logic [3:0] PART = 4'hA; // Arbitrary value
  localparam logic [3:0] REV = 4'h5;  // Arbitrary value
  logic ref_clk, link_clk, resetn, conv_done, manual_start, manual_active;
  logic cmd_valid, wr_valid, rd_valid, power_on, adc_enable, integration_halt, irq_n;
  logic [7:0] cmd_byte, wr_byte, rd_byte, lo, hi;
  logic [15:0] ch0_in, ch1_in;
  int n_fail = 0;
  int n_tests = 0;

  lsr_readout #(.PART_NUMBER(PART), .SILICON_REVISION(REV), .TICK_CYC(4)) DUT (
    .ref_clk(ref_clk), .resetn(resetn), .link_clk(link_clk), .cmd_valid(cmd_valid),
    .cmd_byte(cmd_byte), .wr_valid(wr_valid), .wr_byte(wr_byte), .rd_valid(rd_valid),
    .rd_byte(rd_byte), .conv_done(conv_done), .ch0_in(ch0_in), .ch1_in(ch1_in),
    .manual_start(manual_start), .manual_active(manual_active), .power_on(power_on),
    .adc_enable(adc_enable), .integration_halt(integration_halt), .irq_n(irq_n));

  lsr_host_model host (.link_clk(link_clk), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .wr_valid(wr_valid), .wr_byte(wr_byte), .rd_valid(rd_valid), .rd_byte(rd_byte));

  // ------------------------------------------------------------
  // Clocks and helpers
  // ------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    link_clk = 1'b0;
    #7;
    forever #16 link_clk = ~link_clk;
  end

  task automatic rtick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic idle_inputs();
    conv_done = 1'b0;
    ch0_in = 16'h0000;
    ch1_in = 16'h0000;
    manual_start = 1'b0;
    manual_active = 1'b0;
  endtask

  // Covers both crossings with margin; no completion flag exists
  task automatic wreg(input logic [7:0] c, input logic [7:0] v);
    host.cmd(c);
    host.wr(v);
    rtick(30);
  endtask

  task automatic clr();
    host.cmd(8'hE1);
    rtick(30);
  endtask

  task automatic conv(input logic [15:0] c0, input logic [15:0] c1);
    @(posedge ref_clk);
    #1;
    conv_done = 1'b1;
    ch0_in = c0;
    ch1_in = c1;
    rtick(1);
    conv_done = 1'b0;
    rtick(2);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    `CHK(irq_n, 1'b1)
    `CHK(power_on, 1'b0)
    `CHK(integration_halt, 1'b0)
    host.cmd(8'h92);
    host.wr(8'h33);
    host.rd(lo);
    `CHK(lo, {PART, REV})
    host.rd_word(8'hB4, lo, hi);
    `CHK({hi, lo}, 16'h0000)
    host.rd_word(8'hB6, lo, hi);
    `CHK({hi, lo}, 16'h0000)
    host.cmd(8'h9E);
    host.rd(lo);
    `CHK(lo, 8'h00)
    host.cmd(8'h9F);
    host.rd(lo);
    `CHK(lo, 8'h00)
    $display("reset and identity test done");
  endtask

  task automatic t_power();
    wreg(8'h80, 8'h01);
    `CHK({power_on, adc_enable}, 2'b10)
    wreg(8'h81, 8'hB6);
    wreg(8'h80, 8'h03);
    `CHK({power_on, adc_enable}, 2'b11)
    $display("power-up test done");
  endtask

  task automatic t_shadow();
    conv(16'h1234, 16'h5678);
    rtick(30);
    host.cmd(8'hB4);
    host.rd(lo);
    conv(16'hABCD, 16'h9876);
    rtick(30);
    host.rd(hi);
    `CHK({hi, lo}, 16'h1234)
    host.rd_word(8'hB6, lo, hi);
    `CHK({hi, lo}, 16'h9876)
    host.rd_word(8'hB4, lo, hi);
    `CHK({hi, lo}, 16'hABCD)
    `CHK(irq_n, 1'b1)
    $display("shadow and word read test done");
  endtask

  task automatic t_persist();
    host.cmd(8'hA3);
    host.wr(8'h00);
    host.wr(8'h01);
    host.wr(8'h00);
    wreg(8'h02, 8'h02);
    wreg(8'h82, 8'h10);
    conv(16'h0150, 16'h0000);
    `CHK(irq_n, 1'b0)
    clr();
    `CHK(irq_n, 1'b1)
    wreg(8'h82, 8'h11);
    conv(16'h0150, 16'hFFFF);
    conv(16'h0200, 16'h0000);
    `CHK(irq_n, 1'b1)
    conv(16'h0100, 16'h0000);
    rtick(8);
    `CHK(irq_n, 1'b0)
    clr();
    wreg(8'h82, 8'h13);
    conv(16'h0201, 16'h0000);
    conv(16'h0201, 16'h0000);
    conv(16'h0150, 16'h0000);
    conv(16'h0201, 16'h0000);
    conv(16'h0201, 16'h0000);
    `CHK(irq_n, 1'b1)
    conv(16'hFFFF, 16'h0000);
    `CHK(irq_n, 1'b0)
    clr();
    wreg(8'h82, 8'h01);
    conv(16'h0000, 16'h0000);
    `CHK(irq_n, 1'b1)
    $display("threshold and persistence test done");
  endtask

  task automatic t_halt();
    wreg(8'h82, 8'h51);
    conv(16'h0050, 16'h0000);
    `CHK({irq_n, integration_halt}, 2'b01)
    conv(16'h0150, 16'h0000);
    rtick(30);
    host.rd_word(8'hB4, lo, hi);
    `CHK({hi, lo}, 16'h0050)
    wreg(8'h80, 8'h01);
    clr();
    wreg(8'h80, 8'h03);
    `CHK({irq_n, integration_halt}, 2'b10)
    $display("halt on interrupt test done");
  endtask

  task automatic t_manual();
    @(posedge ref_clk);
    #1;
    manual_start = 1'b1;
    rtick(1);
    manual_start = 1'b0;
    manual_active = 1'b1;
    rtick(40);
    manual_active = 1'b0;
    rtick(30);
    host.rd_word(8'hB8, lo, hi);
    `CHK({hi, lo}, 16'h000A)
    $display("manual tick counter test done");
  endtask

  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    idle_inputs();
    repeat (8) @(posedge ref_clk);
    // Link side resets through two flops, so it needs its own edges
    repeat (4) @(posedge link_clk);
    rtick(1);
    resetn = 1'b1;
    repeat (3) @(posedge link_clk);
    t_reset();
    t_power();
    t_shadow();
    t_persist();
    t_halt();
    t_manual();
    tally_and_finish();
  end

  initial begin
    #200000;
    n_fail++;
    $display("watchdog expired");
    tally_and_finish();
  end
endmodule

`default_nettype wire
